// ==== spm_pkg.sv ====
// spm_pkg: register map, field layout, reset values and selector codes
// for the status pin select and miscellaneous register bank.
// assumes an 8-bit register port with 13-bit register addresses.
package spm_pkg;

    // register address and data widths
    localparam int SPM_AW = 13;
    localparam int SPM_DW = 8;

    // register addresses
    localparam logic [12:0] SPM_ADDR_PIN_CFG = 13'h16e;
    localparam logic [12:0] SPM_ADDR_FIXED_A = 13'h171;
    localparam logic [12:0] SPM_ADDR_FIXED_B = 13'h172;
    localparam logic [12:0] SPM_ADDR_PD = 13'h173;
    localparam logic [12:0] SPM_ADDR_TUNE_A = 13'h17c;
    localparam logic [12:0] SPM_ADDR_TUNE_B = 13'h17d;

    // field positions in the pin configuration register
    localparam int SPM_SEL_MSB = 7;
    localparam int SPM_SEL_LSB = 3;
    localparam int SPM_TYPE_MSB = 2;
    localparam int SPM_TYPE_LSB = 0;

    // field positions in the powerdown register
    localparam int SPM_PRE_PD_BIT = 6;
    localparam int SPM_LOOP_PD_BIT = 5;
    localparam logic [7:0] SPM_PD_MASK = 8'h60;

    // reset values
    localparam logic [4:0] SPM_SEL_RESET = 5'h02;
    localparam logic [2:0] SPM_TYPE_RESET = 3'h6;
    localparam logic [7:0] SPM_FIXED_A_RESET = 8'h0a;
    localparam logic [7:0] SPM_FIXED_B_RESET = 8'h00;
    localparam logic [7:0] SPM_ZERO = 8'h00;

    // source selector codes
    localparam logic [4:0] SPM_SRC_LOW = 5'h00;
    localparam logic [4:0] SPM_SRC_LOOP1 = 5'h01;
    localparam logic [4:0] SPM_SRC_LOOP2 = 5'h02;
    localparam logic [4:0] SPM_SRC_BOTH = 5'h03;
    localparam logic [4:0] SPM_SRC_HOLD = 5'h04;
    localparam logic [4:0] SPM_SRC_DAC_LOCK = 5'h05;
    localparam logic [4:0] SPM_SRC_READBACK = 5'h07;
    localparam logic [4:0] SPM_SRC_DAC_RAIL = 5'h08;
    localparam logic [4:0] SPM_SRC_DAC_LOW = 5'h09;
    localparam logic [4:0] SPM_SRC_DAC_HIGH = 5'h0a;
    localparam logic [4:0] SPM_SRC_DIV_BASE = 5'h0b;
    localparam logic [4:0] SPM_SRC_DIV_LAST = 5'h12;

    // number of loop divider outputs (loop1 n, loop2 n, loop1 r, loop2 r)
    localparam int SPM_NDIV = 4;

    // drive type codes
    localparam logic [2:0] SPM_TYPE_PUSH = 3'h3;
    localparam logic [2:0] SPM_TYPE_PUSH_INV = 3'h4;
    localparam logic [2:0] SPM_TYPE_OPEN_DRAIN = 3'h6;

endpackage

// ==== spm_pin_driver.sv ====
// spm_pin_driver: chooses the indicator for the second status pin,
// makes halved copies of the loop divider outputs and applies the
// drive type. assumes every indicator is synchronous to clk_i.
`timescale 1ns/1ns
module spm_pin_driver
    import spm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] lock_pin_source_select_i,
    input wire logic [2:0] lock_pin_drive_type_i,
    input wire logic loop_one_lock_i,
    input wire logic loop_two_lock_i,
    input wire logic holdover_i,
    input wire logic dac_locked_i,
    input wire logic readback_i,
    input wire logic dac_rail_i,
    input wire logic dac_low_i,
    input wire logic dac_high_i,
    input wire logic [spm_pkg::SPM_NDIV-1:0] divider_i,
    output logic second_status_pin_o,
    output logic second_status_pin_oe_o
);
    import spm_pkg::*;

    logic [SPM_NDIV-1:0] div_prev; // last divider level
    logic [SPM_NDIV-1:0] div_half; // halved divider outputs
    logic [SPM_NDIV-1:0] next_div_prev;
    logic [SPM_NDIV-1:0] next_div_half;
    logic sel_level; // chosen indicator before drive type
    logic next_pin;
    logic next_oe;
    logic [4:0] div_idx; // offset into divider codes
    logic [2:0] div_pos; // divider pair index

    // each divider toggles its halved copy on a rising edge
    genvar g;
    generate
        for (g = 0; g < SPM_NDIV; g++) begin : g_half
            always_comb begin
                next_div_prev[g] = divider_i[g];
                next_div_half[g] = div_half[g] ^
                    (divider_i[g] & ~div_prev[g]);
            end
        end
    endgenerate

    // source selector: unlisted codes fall to low
    always_comb begin
        sel_level = 1'b0;
        div_idx = lock_pin_source_select_i - SPM_SRC_DIV_BASE;
        div_pos = div_idx[3:1];
        case (lock_pin_source_select_i)
            SPM_SRC_LOW: sel_level = 1'b0;
            SPM_SRC_LOOP1: sel_level = loop_one_lock_i;
            SPM_SRC_LOOP2: sel_level = loop_two_lock_i;
            SPM_SRC_BOTH: sel_level = loop_one_lock_i & loop_two_lock_i;
            SPM_SRC_HOLD: sel_level = holdover_i;
            SPM_SRC_DAC_LOCK: sel_level = dac_locked_i;
            SPM_SRC_READBACK: sel_level = readback_i;
            SPM_SRC_DAC_RAIL: sel_level = dac_rail_i;
            SPM_SRC_DAC_LOW: sel_level = dac_low_i;
            SPM_SRC_DAC_HIGH: sel_level = dac_high_i;
            default: begin
                // divider codes come in pairs: full then halved
                if (lock_pin_source_select_i >= SPM_SRC_DIV_BASE &&
                    lock_pin_source_select_i <= SPM_SRC_DIV_LAST) begin
                    sel_level = div_idx[0] ? div_half[div_pos[1:0]]
                                           : divider_i[div_pos[1:0]];
                end else begin
                    sel_level = 1'b0;
                end
            end
        endcase
    end

    // drive type: reserved codes release the pin
    always_comb begin
        next_pin = 1'b0;
        next_oe = 1'b0;
        case (lock_pin_drive_type_i)
            SPM_TYPE_PUSH: begin
                next_pin = sel_level;
                next_oe = 1'b1;
            end
            SPM_TYPE_PUSH_INV: begin
                next_pin = ~sel_level;
                next_oe = 1'b1;
            end
            SPM_TYPE_OPEN_DRAIN: begin
                next_pin = 1'b0;
                next_oe = ~sel_level;
            end
            default: begin
                next_pin = 1'b0;
                next_oe = 1'b0;
            end
        endcase
    end

    // register pin, enable and divider state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_prev <= '0;
            div_half <= '0;
            second_status_pin_o <= 1'b0;
            second_status_pin_oe_o <= 1'b0;
        end else begin
            div_prev <= next_div_prev;
            div_half <= next_div_half;
            second_status_pin_o <= next_pin;
            second_status_pin_oe_o <= next_oe;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_sel_low;
        lock_pin_source_select_i == SPM_SRC_LOW &&
        lock_pin_drive_type_i == SPM_TYPE_PUSH |=>
        second_status_pin_oe_o && !second_status_pin_o;
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("low source did not drive pin low");

    property p_sel_both;
        lock_pin_source_select_i == SPM_SRC_BOTH &&
        lock_pin_drive_type_i == SPM_TYPE_PUSH |=>
        second_status_pin_o == $past(loop_one_lock_i && loop_two_lock_i);
    endproperty
    a_sel_both: assert property (p_sel_both)
        else $error("both-locks source gave wrong level");

    property p_inverted;
        lock_pin_source_select_i == SPM_SRC_LOOP2 &&
        lock_pin_drive_type_i == SPM_TYPE_PUSH_INV |=>
        second_status_pin_oe_o &&
        second_status_pin_o == !$past(loop_two_lock_i);
    endproperty
    a_inverted: assert property (p_inverted)
        else $error("inverted push-pull gave wrong level");

    property p_open_drain;
        lock_pin_drive_type_i == SPM_TYPE_OPEN_DRAIN |=>
        !second_status_pin_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin drove high");

    property p_reserved_sel;
        (lock_pin_source_select_i == 5'h06 ||
         lock_pin_source_select_i > SPM_SRC_DIV_LAST) &&
        lock_pin_drive_type_i == SPM_TYPE_PUSH |=>
        !second_status_pin_o;
    endproperty
    a_reserved_sel: assert property (p_reserved_sel)
        else $error("reserved source did not give low");

    c_open_drain: cover property (
        lock_pin_drive_type_i == SPM_TYPE_OPEN_DRAIN ##1
        second_status_pin_oe_o);
    c_div_half: cover property (
        lock_pin_source_select_i == 5'h0c ##1 second_status_pin_o);
endmodule

// ==== spm_regs.sv ====
// spm_regs: status pin select, fixed and powerdown register bank.
// assumes a simple synchronous register port: one write or read per
// clock, 13-bit address, 8-bit data, reads answered one cycle later.
`timescale 1ns/1ns
module spm_regs
    import spm_pkg::*;
#(
    parameter logic [7:0] PD_RESET = 8'h00, // powerdown reset value
    parameter logic [7:0] TUNE_A_RESET = 8'h00, // tuning word a reset
    parameter logic [7:0] TUNE_B_RESET = 8'h00 // tuning word b reset
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [spm_pkg::SPM_AW-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [spm_pkg::SPM_DW-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [spm_pkg::SPM_DW-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic loop_one_lock_i,
    input wire logic loop_two_lock_i,
    input wire logic holdover_i,
    input wire logic dac_locked_i,
    input wire logic readback_i,
    input wire logic dac_rail_i,
    input wire logic dac_low_i,
    input wire logic dac_high_i,
    input wire logic [spm_pkg::SPM_NDIV-1:0] divider_i,
    output logic second_status_pin_o,
    output logic second_status_pin_oe_o,
    output logic loop_two_powerdown_o,
    output logic loop_two_prescaler_powerdown_o,
    output logic [spm_pkg::SPM_DW-1:0] vco_tuning_word_a_o,
    output logic [spm_pkg::SPM_DW-1:0] vco_tuning_word_b_o
);
    import spm_pkg::*;

    logic [4:0] lock_pin_source_select; // pin source code
    logic [2:0] lock_pin_drive_type; // pin drive mode
    logic [7:0] fixed_value_a; // fixed register a
    logic [7:0] fixed_value_b; // fixed register b
    logic [7:0] loop_two_powerdown; // powerdown bits only
    logic [7:0] vco_tuning_word_a; // tuning word a
    logic [7:0] vco_tuning_word_b; // tuning word b
    logic [4:0] next_sel;
    logic [2:0] next_type;
    logic [7:0] next_fixed_a;
    logic [7:0] next_fixed_b;
    logic [7:0] next_pd;
    logic [7:0] next_tune_a;
    logic [7:0] next_tune_b;
    logic [7:0] next_rdata;
    logic next_rvalid;

    // register writes: decode address and update one register
    always_comb begin
        next_sel = lock_pin_source_select;
        next_type = lock_pin_drive_type;
        next_fixed_a = fixed_value_a;
        next_fixed_b = fixed_value_b;
        next_pd = loop_two_powerdown;
        next_tune_a = vco_tuning_word_a;
        next_tune_b = vco_tuning_word_b;
        if (reg_wr_i) begin
            if (reg_addr_i == SPM_ADDR_PIN_CFG) begin
                next_sel = reg_wdata_i[SPM_SEL_MSB:SPM_SEL_LSB];
                next_type = reg_wdata_i[SPM_TYPE_MSB:SPM_TYPE_LSB];
            end else if (reg_addr_i == SPM_ADDR_FIXED_A) begin
                next_fixed_a = reg_wdata_i;
            end else if (reg_addr_i == SPM_ADDR_FIXED_B) begin
                next_fixed_b = reg_wdata_i;
            end else if (reg_addr_i == SPM_ADDR_PD) begin
                // reserved bits are not stored
                next_pd = reg_wdata_i & SPM_PD_MASK;
            end else if (reg_addr_i == SPM_ADDR_TUNE_A) begin
                next_tune_a = reg_wdata_i;
            end else if (reg_addr_i == SPM_ADDR_TUNE_B) begin
                next_tune_b = reg_wdata_i;
            end
        end
    end

    // register reads: unmapped addresses read zero
    always_comb begin
        next_rdata = SPM_ZERO;
        next_rvalid = reg_rd_i;
        if (reg_rd_i) begin
            if (reg_addr_i == SPM_ADDR_PIN_CFG) begin
                next_rdata = {lock_pin_source_select, lock_pin_drive_type};
            end else if (reg_addr_i == SPM_ADDR_FIXED_A) begin
                next_rdata = fixed_value_a;
            end else if (reg_addr_i == SPM_ADDR_FIXED_B) begin
                next_rdata = fixed_value_b;
            end else if (reg_addr_i == SPM_ADDR_PD) begin
                next_rdata = loop_two_powerdown;
            end else if (reg_addr_i == SPM_ADDR_TUNE_A) begin
                next_rdata = vco_tuning_word_a;
            end else if (reg_addr_i == SPM_ADDR_TUNE_B) begin
                next_rdata = vco_tuning_word_b;
            end
        end
    end

    // register state and read answer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_pin_source_select <= SPM_SEL_RESET;
            lock_pin_drive_type <= SPM_TYPE_RESET;
            fixed_value_a <= SPM_FIXED_A_RESET;
            fixed_value_b <= SPM_FIXED_B_RESET;
            loop_two_powerdown <= PD_RESET & SPM_PD_MASK;
            vco_tuning_word_a <= TUNE_A_RESET;
            vco_tuning_word_b <= TUNE_B_RESET;
            reg_rdata_o <= SPM_ZERO;
            reg_rvalid_o <= 1'b0;
        end else begin
            lock_pin_source_select <= next_sel;
            lock_pin_drive_type <= next_type;
            fixed_value_a <= next_fixed_a;
            fixed_value_b <= next_fixed_b;
            loop_two_powerdown <= next_pd;
            vco_tuning_word_a <= next_tune_a;
            vco_tuning_word_b <= next_tune_b;
            reg_rdata_o <= next_rdata;
            reg_rvalid_o <= next_rvalid;
        end
    end

    // powerdown and tuning outputs straight from the registers
    assign loop_two_prescaler_powerdown_o =
        loop_two_powerdown[SPM_PRE_PD_BIT];
    assign loop_two_powerdown_o =
        loop_two_powerdown[SPM_LOOP_PD_BIT];
    assign vco_tuning_word_a_o = vco_tuning_word_a;
    assign vco_tuning_word_b_o = vco_tuning_word_b;

    // selector and drive stage for the second status pin
    spm_pin_driver u_pin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lock_pin_source_select_i(lock_pin_source_select),
        .lock_pin_drive_type_i(lock_pin_drive_type),
        .loop_one_lock_i(loop_one_lock_i),
        .loop_two_lock_i(loop_two_lock_i),
        .holdover_i(holdover_i),
        .dac_locked_i(dac_locked_i),
        .readback_i(readback_i),
        .dac_rail_i(dac_rail_i),
        .dac_low_i(dac_low_i),
        .dac_high_i(dac_high_i),
        .divider_i(divider_i),
        .second_status_pin_o(second_status_pin_o),
        .second_status_pin_oe_o(second_status_pin_oe_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_pre_pd;
        reg_wr_i && reg_addr_i == SPM_ADDR_PD |=>
        loop_two_prescaler_powerdown_o == $past(reg_wdata_i[SPM_PRE_PD_BIT]);
    endproperty
    a_pre_pd: assert property (p_pre_pd)
        else $error("prescaler powerdown did not follow write");

    property p_loop_pd;
        reg_wr_i && reg_addr_i == SPM_ADDR_PD |=>
        loop_two_powerdown_o == $past(reg_wdata_i[SPM_LOOP_PD_BIT]);
    endproperty
    a_loop_pd: assert property (p_loop_pd)
        else $error("loop powerdown did not follow write");

    property p_pd_reserved;
        reg_rd_i && reg_addr_i == SPM_ADDR_PD |=>
        (reg_rdata_o & ~SPM_PD_MASK) == SPM_ZERO;
    endproperty
    a_pd_reserved: assert property (p_pd_reserved)
        else $error("reserved powerdown bits read nonzero");

    property p_cfg_readback;
        reg_wr_i && reg_addr_i == SPM_ADDR_PIN_CFG ##1
        reg_rd_i && !reg_wr_i && reg_addr_i == SPM_ADDR_PIN_CFG |=>
        reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("pin configuration read back wrong");

    property p_pd_hold;
        !(reg_wr_i && reg_addr_i == SPM_ADDR_PD) |=>
        $stable(loop_two_powerdown_o) &&
        $stable(loop_two_prescaler_powerdown_o);
    endproperty
    a_pd_hold: assert property (p_pd_hold)
        else $error("powerdown changed without a write");

    c_pd_write: cover property (
        reg_wr_i && reg_addr_i == SPM_ADDR_PD ##1 loop_two_powerdown_o);
    c_cfg_read: cover property (
        reg_rd_i && reg_addr_i == SPM_ADDR_PIN_CFG ##1 reg_rvalid_o);
endmodule

// ==== spm_pin_model.sv ====
// spm_pin_model: board wire on the second status pin, with a pull-up.
// assumes pin value and enable come straight from the register bank.
`timescale 1ns/1ns
module spm_pin_model (
    input wire logic pin_i,
    input wire logic pin_oe_i,
    output logic wire_level_o
);
    // a released pin is pulled high, a driven pin shows its value
    always_comb begin
        wire_level_o = pin_oe_i ? pin_i : 1'b1;
    end
endmodule

// ==== spm_testbench.sv ====
// spm_testbench: register reads and writes plus status pin checks.
// assumes the register bank answers reads one cycle after the strobe.
`timescale 1ns/1ns
module testbench;
    import spm_pkg::*;
    logic clk_i; // 125 mhz clock
    logic rst_i; // active high reset
    logic reg_wr_i, reg_rd_i; // access strobes
    logic [12:0] reg_addr_i; // register address
    logic [7:0] reg_wdata_i; // write data
    logic [7:0] ind; // indicator levels, loop1 lock first
    logic [3:0] div; // divider inputs
    logic [3:0] half; // expected halved divider copies
    logic [7:0] reg_rdata_o, tune_a, tune_b;
    logic reg_rvalid_o, pin, pin_oe, pd_loop, pd_pre, wire_lvl;
    int bad_count;
    int samples_checked;
    // reset table of the mapped registers
    logic [12:0] ra [6] = '{SPM_ADDR_PIN_CFG, SPM_ADDR_FIXED_A,
        SPM_ADDR_FIXED_B, SPM_ADDR_PD, SPM_ADDR_TUNE_A, SPM_ADDR_TUNE_B};
    logic [7:0] rv [6] = '{8'h16, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] pv [5] = '{8'hff, 8'h40, 8'h20, 8'h9f, 8'h00};
    logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h55, 8'haa};

    spm_regs u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o),
        .loop_one_lock_i(ind[0]),
        .loop_two_lock_i(ind[1]),
        .holdover_i(ind[2]),
        .dac_locked_i(ind[3]),
        .readback_i(ind[4]),
        .dac_rail_i(ind[5]),
        .dac_low_i(ind[6]),
        .dac_high_i(ind[7]),
        .divider_i(div),
        .second_status_pin_o(pin),
        .second_status_pin_oe_o(pin_oe),
        .loop_two_powerdown_o(pd_loop),
        .loop_two_prescaler_powerdown_o(pd_pre),
        .vco_tuning_word_a_o(tune_a),
        .vco_tuning_word_b_o(tune_b)
    );

    spm_pin_model u_pin (
        .pin_i(pin),
        .pin_oe_i(pin_oe),
        .wire_level_o(wire_lvl)
    );

    // free running clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // compare and count
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // verdict and end of run
    task complete_run;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one write strobe, driven at the falling edge
    task wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    // one read strobe, answer awaited under a bound
    task rd(input logic [12:0] a, output logic [7:0] d);
        int i;
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        i = 0;
        while (reg_rvalid_o !== 1'b1 && i < 4) begin
            @(negedge clk_i);
            i++;
        end
        if (i == 4) begin
            bad_count++;
            complete_run();
        end
        chk("read latency", 8'h00, 8'(i));
        d = reg_rdata_o;
    endtask

    // read and compare
    task rd_chk(input string n, input logic [12:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask

    // write, then read the same register at the very next edge;
    // the answer stands one cycle and then drops back to zero
    task wr_rd(input logic [12:0] a, input logic [7:0] d,
               input logic [7:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        chk("back to back valid", 8'h01, {7'h00, reg_rvalid_o});
        chk("back to back data", e, reg_rdata_o);
        @(negedge clk_i);
        chk("valid one cycle", 8'h00, {7'h00, reg_rvalid_o});
        chk("data one cycle", 8'h00, reg_rdata_o);
    endtask

    // let sampled inputs reach the registered pin
    task settle;
        repeat (4) @(negedge clk_i);
    endtask

    // expected indicator level for a source code
    function automatic logic lvl(input logic [4:0] c);
        int m [11] = '{-1, 0, 1, -1, 2, 3, -1, 4, 5, 6, 7};
        int k;
        k = (int'(c) - 11) / 2;
        if (c == 5'h03) return ind[0] & ind[1];
        if (c <= 5'h0a) return (m[c] < 0) ? 1'b0 : ind[m[c]];
        if (c <= 5'h12) return c[0] ? div[k] : half[k];
        return 1'b0;
    endfunction

    // set source and drive type, then check pin, enable and wire
    task chk_pin(input logic [4:0] c, input logic [2:0] t);
        logic l;
        logic [2:0] e;
        wr(SPM_ADDR_PIN_CFG, {c, t});
        settle();
        l = lvl(c);
        case (t)
            3'h3: e = {l, 1'b1, l};
            3'h4: e = {~l, 1'b1, ~l};
            3'h6: e = {1'b0, ~l, l};
            default: e = 3'b001;
        endcase
        chk("status pin", {5'h00, e},
            {5'h00, pin, pin_oe, wire_lvl});
    endtask

    // main sequence
    initial begin
        rst_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 13'h0000;
        reg_wdata_i = 8'h00;
        ind = 8'h00;
        div = 4'h0;
        half = 4'h0;
        bad_count = 0;
        samples_checked = 0;
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        // power-on values
        foreach (ra[i]) rd_chk("reset value", ra[i], rv[i]);
        chk("reset powerdown", 8'h00, {6'h00, pd_loop, pd_pre});
        chk("default pin", 8'h02,
            {5'h00, pin, pin_oe, wire_lvl});
        // required software values, tuning words ahead of 0x168
        wr(SPM_ADDR_FIXED_A, 8'haa);
        wr(SPM_ADDR_FIXED_B, 8'h02);
        wr(SPM_ADDR_TUNE_A, 8'h15);
        wr(SPM_ADDR_TUNE_B, 8'h33);
        wr(13'h168, 8'hff);
        rd_chk("fixed a", SPM_ADDR_FIXED_A, 8'haa);
        rd_chk("fixed b", SPM_ADDR_FIXED_B, 8'h02);
        rd_chk("tune a", SPM_ADDR_TUNE_A, 8'h15);
        rd_chk("tune b", SPM_ADDR_TUNE_B, 8'h33);
        rd_chk("unmapped", 13'h168, 8'h00);
        chk("tune a out", 8'h15, tune_a);
        chk("tune b out", 8'h33, tune_b);
        // powerdown bits, reserved bits dropped
        foreach (pv[i]) begin
            wr(SPM_ADDR_PD, pv[i]);
            rd_chk("powerdown", SPM_ADDR_PD, pv[i] & 8'h60);
            chk("loop pd", {7'h00, pv[i][5]}, {7'h00, pd_loop});
            chk("pre pd", {7'h00, pv[i][6]}, {7'h00, pd_pre});
        end
        // every source code with several indicator patterns
        for (int c = 0; c < 32; c++) begin
            foreach (pat[p]) begin
                ind = pat[p];
                chk_pin(5'(c), SPM_TYPE_PUSH);
            end
        end
        // divider and halved copies; codes 17 and 18 assume the
        // first pin is not on a loop2 lock source
        ind = 8'h00;
        for (int i = 0; i < 4; i++) begin
            repeat (2) begin
                div[i] = 1'b1;
                half[i] = ~half[i];
                chk_pin(5'(11 + 2 * i), SPM_TYPE_PUSH);
                chk_pin(5'(12 + 2 * i), SPM_TYPE_PUSH);
                div[i] = 1'b0;
                chk_pin(5'(11 + 2 * i), SPM_TYPE_PUSH);
                chk_pin(5'(12 + 2 * i), SPM_TYPE_PUSH);
            end
        end
        // drive types, both levels
        for (int l = 0; l < 2; l++) begin
            ind = (l == 1) ? 8'h01 : 8'h00;
            for (int t = 0; t < 8; t++) begin
                chk_pin(5'h01, 3'(t));
            end
        end
        // read straight after write, reserved powerdown bits dropped
        wr_rd(SPM_ADDR_PIN_CFG, 8'h93, 8'h93);
        wr_rd(SPM_ADDR_PD, 8'hff, 8'h60);
        complete_run();
    end
endmodule
